/* hw/brw_flag.sv */
// brw_flag: one interrupt source: rising-edge detect, sticky flag, mask gating.
// assumes clear is a one-cycle pulse from the host read of the flag.
`timescale 1ns/1ps
module brw_flag
(
	input  wire logic clock,
	input  wire logic rstn,
	input  wire logic cond,
	input  wire logic mask,
	input  wire logic clear,
	output logic      flag,
	output logic      rise,
	output logic      fire
);

	// =========================================================================
	// edge, flag and fire
	logic condPrev_reg;
	logic flag_reg;
	logic flag_next;

	assign rise      = cond && !condPrev_reg;
	// only a fresh edge while unmasked and with the flag clear raises a pulse
	assign fire      = rise && !mask && !flag_reg;
	// set wins over a clear in the same cycle
	assign flag_next = rise || (flag_reg && !clear);
	assign flag      = flag_reg;

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			condPrev_reg <= 1'b0;
			flag_reg     <= 1'b0;
		end
		else
		begin
			condPrev_reg <= cond;
			flag_reg     <= flag_next;
		end
	end

	// =========================================================================
	// checks
	AST_MASK_BLOCKS: assert property (@(posedge clock) disable iff (!rstn)
		mask && cond && !condPrev_reg |-> !fire)
		else $error("masked edge produced a pulse");

	AST_UNMASK_QUIET: assert property (@(posedge clock) disable iff (!rstn)
		$fell(mask) && cond && $past(cond) |-> !fire)
		else $error("unmask with standing condition produced a pulse");

	AST_FLAG_STICKY: assert property (@(posedge clock) disable iff (!rstn)
		flag_reg && !clear |=> flag_reg && !fire)
		else $error("flag dropped without clear or fired again while set");

endmodule // brw_flag

/* hw/brw_timer.sv */
// brw_timer: saturating up-counter with synchronous clear.
// assumes an active-low asynchronous reset already synchronised by the parent.
`timescale 1ns/1ps
module brw_timer
#(
	parameter int W = 16
)
(
	input  wire logic         clock,
	input  wire logic         rstn,
	input  wire logic         clear,
	input  wire logic         run,
	output logic [W-1:0]      count
);

	// =========================================================================
	// counter
	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;
	wire  logic   atTop = &count_reg;

	// saturates so a stalled timer cannot wrap into a false expiry
	assign count_next = clear ? '0 : ((run && !atTop) ? count_reg + 1'b1 : count_reg);
	assign count      = count_reg;

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			count_reg <= '0;
		else
			count_reg <= count_next;
	end

endmodule // brw_timer

/* hw/brw_top.sv */
// brw_top: long-press action, reset warning, adapter watchdog, interrupt pulse, charger flags.
// assumes all inputs synchronous to clock except the button; flag clears are read pulses.
`timescale 1ns/1ps
module brw_top
#(
	parameter int TICK_CYCLES      = brw_pkg::TICK_CYCLES,
	parameter int INT_PULSE_CYCLES = brw_pkg::INT_PULSE_CYCLES,
	parameter int WATCHDOG_TICKS   = brw_pkg::WATCHDOG_TICKS,
	parameter int RAIL_OFF_TICKS   = brw_pkg::RAIL_OFF_TICKS
)
(
	input  wire logic                       clock,
	input  wire logic                       rstn,
	input  wire logic                       buttonInputN,
	input  wire brw_pkg::brw_action_t       longPressActionSel,
	input  wire logic [brw_pkg::MS_W-1:0]   longPressResetMs,
	input  wire logic [brw_pkg::MS_W-1:0]   resetWarnLeadMs,
	input  wire logic                       resetNeedsInputPower,
	input  wire logic                       inputSupplyValid,
	input  wire logic                       softResetRequest,
	input  wire logic                       adapterWatchdogEnable,
	input  wire logic                       busTransaction,
	input  wire logic                       startupDone,
	input  wire logic                       startupFault,
	input  wire brw_pkg::brw_status_t       chargerStatus,
	input  wire logic                       chargeEnableToggle,
	input  wire logic                       rechargeReached,
	input  wire logic                       timerDoubleOption,
	input  wire brw_pkg::brw_flags_t        flagMask,
	input  wire brw_pkg::brw_flags_t        flagClear,
	output brw_pkg::brw_flags_t             flagsOut,
	output logic                            intOut,
	output logic                            intOutEn,
	output logic                            systemRailEnable,
	output logic                            alwaysOnRailEnable,
	output logic                            hwResetActive,
	output logic                            shipModeEntry,
	output logic                            chargePause,
	output logic                            safetyTimerReset,
	output logic                            safetyTimerDouble
);

	// =========================================================================
	// reset release and button synchroniser
	logic [1:0] rstSync_reg;
	logic       rstnInt;
	logic       btnMeta_reg;
	logic       btnSync_reg;

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			rstSync_reg <= 2'h0;
		else
			rstSync_reg <= {rstSync_reg[0], 1'b1};
	end
	assign rstnInt = rstSync_reg[1];

	always_ff @(posedge clock or negedge rstnInt)
	begin
		if (!rstnInt)
		begin
			btnMeta_reg <= 1'b1;
			btnSync_reg <= 1'b1;
		end
		else
		begin
			btnMeta_reg <= buttonInputN;
			btnSync_reg <= btnMeta_reg;
		end
	end

	// =========================================================================
	// millisecond timebase, free running
	localparam logic [brw_pkg::TICK_W-1:0]  TICK_LAST  = brw_pkg::TICK_W'(TICK_CYCLES - 1);
	localparam logic [brw_pkg::MS_W-1:0]    WD_LAST    = brw_pkg::MS_W'(WATCHDOG_TICKS);
	localparam logic [brw_pkg::MS_W-1:0]    RAIL_LAST  = brw_pkg::MS_W'(RAIL_OFF_TICKS - 1);
	localparam logic [brw_pkg::PULSE_W-1:0] PULSE_LAST = brw_pkg::PULSE_W'(INT_PULSE_CYCLES - 1);

	logic [brw_pkg::TICK_W-1:0] tickCount;
	wire  logic                 tickHit = (tickCount == TICK_LAST);

	brw_timer #(.W(brw_pkg::TICK_W)) u_tick
	(
		.clock (clock),
		.rstn  (rstnInt),
		.clear (tickHit),
		.run   (1'b1),
		.count (tickCount)
	);

	// =========================================================================
	// long press measurement and action
	logic                      pressedPrev_reg;
	logic                      lpFired_reg;
	logic                      armReset_reg;
	logic                      vinOk_reg;
	logic [brw_pkg::MS_W-1:0]  lpTime_reg;
	logic [brw_pkg::MS_W-1:0]  warnLead_reg;
	logic [brw_pkg::MS_W-1:0]  pressMs;

	wire logic pressed    = !btnSync_reg;
	wire logic pressStart = pressed && !pressedPrev_reg;
	// the timer durations are frozen for the press so a mid-press rewrite cannot shorten it
	wire logic lpExpire   = pressed && !pressStart && !lpFired_reg && (pressMs >= lpTime_reg);
	wire logic vinOkNow   = vinOk_reg && inputSupplyValid;
	wire logic selReset   = (longPressActionSel == brw_pkg::BRW_LP_SOFT_RESET_REQUEST);
	wire logic selShip    = longPressActionSel[1];
	wire logic lpReset    = lpExpire && selReset && armReset_reg
		&& (!resetNeedsInputPower || vinOkNow);
	wire logic warnCond   = pressed && !pressStart && !lpFired_reg
		&& (({1'b0, pressMs} + {1'b0, warnLead_reg}) >= {1'b0, lpTime_reg});

	brw_timer #(.W(brw_pkg::MS_W)) u_press
	(
		.clock (clock),
		.rstn  (rstnInt),
		.clear (!pressed),
		.run   (pressed && tickHit),
		.count (pressMs)
	);

	always_ff @(posedge clock or negedge rstnInt)
	begin
		if (!rstnInt)
		begin
			pressedPrev_reg <= 1'b0;
			lpFired_reg     <= 1'b0;
			armReset_reg    <= 1'b0;
			vinOk_reg       <= 1'b0;
			lpTime_reg      <= '0;
			warnLead_reg    <= '0;
		end
		else
		begin
			pressedPrev_reg <= pressed;
			// one action per press; the button must be released to re-arm
			lpFired_reg     <= pressed && (lpFired_reg || lpExpire);
			if (pressStart)
			begin
				lpTime_reg   <= longPressResetMs;
				warnLead_reg <= resetWarnLeadMs;
				armReset_reg <= selReset;
				vinOk_reg    <= inputSupplyValid;
			end
			else
				vinOk_reg    <= vinOkNow;
		end
	end

	// =========================================================================
	// adapter watchdog
	logic                     supplyPrev_reg;
	logic                     wdArmed_reg;
	logic [brw_pkg::MS_W-1:0] wdCount;

	wire logic adapterConnect = inputSupplyValid && !supplyPrev_reg;
	wire logic supplyToggle   = inputSupplyValid != supplyPrev_reg;
	wire logic wdExpire       = wdArmed_reg && (wdCount == WD_LAST);

	brw_timer #(.W(brw_pkg::MS_W)) u_wd
	(
		.clock (clock),
		.rstn  (rstnInt),
		.clear (!wdArmed_reg || adapterConnect),
		.run   (wdArmed_reg && tickHit),
		.count (wdCount)
	);

	always_ff @(posedge clock or negedge rstnInt)
	begin
		if (!rstnInt)
		begin
			supplyPrev_reg <= 1'b0;
			wdArmed_reg    <= 1'b0;
		end
		else
		begin
			supplyPrev_reg <= inputSupplyValid;
			wdArmed_reg    <= adapterWatchdogEnable && inputSupplyValid
				&& (adapterConnect || (wdArmed_reg && !busTransaction && !wdExpire));
		end
	end

	// =========================================================================
	// hardware reset sequencer
	typedef enum logic {RST_IDLE, RST_OFF} brw_rst_state_t;
	brw_rst_state_t           rstState_reg;
	brw_rst_state_t           rstState_next;
	logic [brw_pkg::MS_W-1:0] railMs;
	logic                     aon_reg;
	logic                     ship_reg;

	wire logic hwResetReq = lpReset || softResetRequest || wdExpire;
	wire logic railDone   = (railMs == RAIL_LAST) && tickHit;

	brw_timer #(.W(brw_pkg::MS_W)) u_rail
	(
		.clock (clock),
		.rstn  (rstnInt),
		.clear (rstState_reg == RST_IDLE),
		.run   ((rstState_reg == RST_OFF) && tickHit),
		.count (railMs)
	);

	always_comb
	begin
		rstState_next = rstState_reg;
		unique case (rstState_reg)
			RST_IDLE: if (hwResetReq) rstState_next = RST_OFF;
			RST_OFF:  if (railDone) rstState_next = RST_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rstnInt)
	begin
		if (!rstnInt)
		begin
			rstState_reg <= RST_IDLE;
			aon_reg      <= 1'b0;
			ship_reg     <= 1'b0;
		end
		else
		begin
			rstState_reg <= rstState_next;
			aon_reg      <= 1'b1;
			ship_reg     <= lpExpire && selShip;
		end
	end

	// only the system rail cycles; the always-on rail is untouched by any hardware reset request
	assign systemRailEnable   = (rstState_reg == RST_IDLE);
	assign alwaysOnRailEnable = aon_reg;
	assign hwResetActive      = (rstState_reg == RST_OFF);
	assign shipModeEntry      = ship_reg;

	// =========================================================================
	// flags and interrupt pulse
	logic [brw_pkg::NUM_FLAGS-1:0] condVec;
	logic [brw_pkg::NUM_FLAGS-1:0] flagVec;
	logic [brw_pkg::NUM_FLAGS-1:0] riseVec;
	logic [brw_pkg::NUM_FLAGS-1:0] fireVec;
	logic                          startSeen_reg;
	logic                          intValid_reg;
	logic                          pulseActive_reg;
	logic [brw_pkg::PULSE_W-1:0]   pulseCount;
	brw_pkg::brw_flags_t           condAll;
	brw_pkg::brw_flags_t           riseAll;

	assign condAll = '{resetWarning: warnCond, src: chargerStatus};
	assign condVec = condAll;
	assign riseAll = riseVec;

	genvar gi;
	generate
		for (gi = 0; gi < brw_pkg::NUM_FLAGS; gi++)
		begin : g_flag
			brw_flag u_flag
			(
				.clock (clock),
				.rstn  (rstnInt),
				.cond  (condVec[gi]),
				.mask  (flagMask[gi]),
				.clear (flagClear[gi]),
				.flag  (flagVec[gi]),
				.rise  (riseVec[gi]),
				.fire  (fireVec[gi])
			);
		end
	endgenerate

	wire logic anyFire   = intValid_reg && (|fireVec);
	wire logic pulseLast = (pulseCount == PULSE_LAST);

	brw_timer #(.W(brw_pkg::PULSE_W)) u_pulse
	(
		.clock (clock),
		.rstn  (rstnInt),
		.clear (anyFire || !pulseActive_reg),
		.run   (pulseActive_reg),
		.count (pulseCount)
	);

	always_ff @(posedge clock or negedge rstnInt)
	begin
		if (!rstnInt)
		begin
			startSeen_reg   <= 1'b0;
			intValid_reg    <= 1'b0;
			pulseActive_reg <= 1'b0;
		end
		else
		begin
			startSeen_reg   <= startSeen_reg || startupDone;
			// a fault at start-up leaves interrupts off until the next reset
			if (startupDone && !startSeen_reg)
				intValid_reg <= !startupFault;
			// a new event during a pulse restarts it rather than being lost
			pulseActive_reg <= anyFire || (pulseActive_reg && !pulseLast);
		end
	end

	assign flagsOut = brw_pkg::brw_flags_t'(flagVec);
	assign intOutEn = pulseActive_reg;
	assign intOut   = 1'b0;

	// =========================================================================
	// charger response
	logic pause_reg;
	logic stReset_reg;
	logic stDouble_reg;

	wire logic loopActive = chargerStatus.inputLimitLoop || chargerStatus.systemDroopLoop
		|| chargerStatus.inputDroopLoop || chargerStatus.thermalFoldback;

	always_ff @(posedge clock or negedge rstnInt)
	begin
		if (!rstnInt)
		begin
			pause_reg    <= 1'b0;
			stReset_reg  <= 1'b0;
			stDouble_reg <= 1'b0;
		end
		else
		begin
			pause_reg    <= riseAll.src.chargeDone
				|| (pause_reg && !supplyToggle && !chargeEnableToggle && !rechargeReached);
			stReset_reg  <= riseAll.src.chargeDone;
			stDouble_reg <= timerDoubleOption && loopActive;
		end
	end

	assign chargePause       = pause_reg;
	assign safetyTimerReset  = stReset_reg;
	assign safetyTimerDouble = stDouble_reg;

	// =========================================================================
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstnInt);

	AST_LP_RESET: assert property (lpReset && rstState_reg == RST_IDLE
		|=> rstState_reg == RST_OFF && !systemRailEnable)
		else $error("long press reset not started on expiry");
	AST_LP_SHIP: assert property (lpExpire && selShip |=> shipModeEntry)
		else $error("ship entry not immediate on expiry");
	AST_WARN_FIRST: assert property ($rose(warnCond) |=> flagsOut.resetWarning)
		else $error("warning flag not set");
	AST_LATE_RESET: assert property (lpExpire && !armReset_reg && !softResetRequest
		&& !wdExpire && rstState_reg == RST_IDLE |=> rstState_reg == RST_IDLE)
		else $error("late change to reset took effect");
	AST_VIN_GATE: assert property (lpExpire && resetNeedsInputPower && !vinOkNow
		&& !softResetRequest && !wdExpire && rstState_reg == RST_IDLE
		|=> rstState_reg == RST_IDLE)
		else $error("reset without supply over whole press");
	AST_SOFT: assert property (softResetRequest && rstState_reg == RST_IDLE
		|=> hwResetActive)
		else $error("soft reset not started");
	AST_AON: assert property (hwResetActive && $past(hwResetActive) |-> alwaysOnRailEnable)
		else $error("always-on rail dropped in reset");
	AST_WD_FIRE: assert property (wdExpire && rstState_reg == RST_IDLE
		|=> hwResetActive ##1 !wdArmed_reg)
		else $error("watchdog expiry did not reset");
	AST_WD_CANCEL: assert property (wdArmed_reg && busTransaction && !adapterConnect
		|=> !wdArmed_reg ##1 wdCount == '0)
		else $error("bus transaction did not cancel watchdog");
	AST_WD_OFF: assert property (!adapterWatchdogEnable |=> !wdArmed_reg)
		else $error("watchdog armed while disabled");
	AST_INT_VALID: assert property ($rose(intOutEn) |-> $past(intValid_reg))
		else $error("interrupt before valid start-up");
	AST_INT_LEN: assert property ($fell(intOutEn) |-> $past(pulseCount) == PULSE_LAST)
		else $error("interrupt pulse length wrong");
	AST_DONE: assert property ($rose(chargerStatus.chargeDone)
		|=> chargePause && safetyTimerReset)
		else $error("termination response missing");
	AST_LOOP: assert property (timerDoubleOption && loopActive |=> safetyTimerDouble)
		else $error("safety timer not doubled");
	AST_CV: assert property ($rose(chargerStatus.constantVoltage)
		&& !$rose(chargerStatus.chargeDone) |=> !safetyTimerReset)
		else $error("constant voltage touched safety timer");
	AST_TICK: assert property (tickHit |=> !tickHit)
		else $error("timebase tick not periodic");

	COV_LP_RESET: cover property (lpReset ##1 hwResetActive);
	COV_WD: cover property (wdExpire);
	COV_INT: cover property ($rose(intOutEn));
	COV_WARN: cover property ($rose(warnCond) ##[1:20] lpExpire);

endmodule // brw_top

/* include/brw_pkg.sv */
// brw_pkg: shared constants and carrier types for the button, reset, watchdog and interrupt block.
// assumes a 250 MHz core clock; the tick and interrupt pulse cycle counts below are expressed from that rate.
package brw_pkg;

	// =========================================================================
	// clock and timebase
	localparam int CLK_PERIOD_NS   = 4;
	localparam int TICK_TIME_NS    = 1_000_000;
	localparam int TICK_CYCLES     = TICK_TIME_NS / CLK_PERIOD_NS;
	localparam int TICK_W          = 18;

	// =========================================================================
	// interrupt pulse: a least time, so round up
	localparam int INT_PULSE_NS     = 128_000;
	localparam int INT_PULSE_CYCLES = (INT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_W          = 16;

	// =========================================================================
	// adapter watchdog and rail cycling, counted in 1 ms ticks
	localparam int WATCHDOG_TIME_S  = 14;
	// ticks per second taken first so the product stays inside 32 bits
	localparam int WATCHDOG_TICKS   = WATCHDOG_TIME_S * (1_000_000_000 / TICK_TIME_NS);
	localparam int RAIL_OFF_TIME_MS = 100;
	localparam int RAIL_OFF_TICKS   = RAIL_OFF_TIME_MS * 1_000_000 / TICK_TIME_NS;
	localparam int MS_W             = 16;

	// =========================================================================
	// flag vector layout and reset values
	localparam int          NUM_FLAGS   = 7;
	localparam logic [6:0]  FLAGS_RESET = 7'h00;

	// =========================================================================
	// types
	typedef enum logic [1:0]
	{
		BRW_LP_SOFT_RESET_REQUEST = 2'h0,
		BRW_LP_NONE     = 2'h1,
		BRW_LP_SHIP     = 2'h2,
		BRW_LP_SHIP_ALT = 2'h3
	} brw_action_t;

	typedef struct packed
	{
		logic constantVoltage;
		logic chargeDone;
		logic inputLimitLoop;
		logic systemDroopLoop;
		logic inputDroopLoop;
		logic thermalFoldback;
	} brw_status_t;

	typedef struct packed
	{
		logic        resetWarning;
		brw_status_t src;
	} brw_flags_t;

endpackage

/* sim/brw_host_model.sv */
// brw_host_model: host on the far side of the bus and the interrupt pin.
// assumes the bench commands each bus transaction and each flag read.
`timescale 1ns/1ps
module brw_host_model
(
	input  wire logic                clock,
	input  wire logic                intOutEn,
	input  wire logic                intOut,
	input  wire logic                doBus,
	input  wire brw_pkg::brw_flags_t doRead,
	output logic                     busTransaction,
	output brw_pkg::brw_flags_t      flagClear,
	output logic                     intPin
);
	// pull-up on the board: the pin reads high whenever the device lets go
	assign intPin = intOutEn ? intOut : 1'b1;
	always_ff @(posedge clock)
	begin
		busTransaction <= doBus;
		flagClear      <= doRead;
	end
endmodule // brw_host_model

/* sim/brw_top_bench.sv */
// brw_top_bench: self-checking bench for brw_top with shortened timing.
// assumes a 4-cycle tick, 8-cycle interrupt pulse, 20-tick watchdog, 3-tick rail off time.
`timescale 1ns/1ps
module brw_top_bench;
	// ====================================================================
	// signals
	localparam int TK = 4;
	localparam int PL = 8;
	localparam int WD = 20;
	localparam int RO = 3;
	localparam brw_pkg::brw_action_t HR = brw_pkg::BRW_LP_SOFT_RESET_REQUEST;
	localparam brw_pkg::brw_action_t NO = brw_pkg::BRW_LP_NONE;
	logic                 clock;
	logic                 rstn = 1'b0;
	logic                 btnN = 1'b1;
	brw_pkg::brw_action_t sel = HR;
	logic [15:0]          pressMs = 16'h0003;
	logic [15:0]          leadMs = 16'h0001;
	logic                 needPwr = 1'b0;
	logic                 supply = 1'b1;
	logic                 softReq = 1'b0;
	logic                 wdEn = 1'b0;
	logic                 doBus = 1'b0;
	logic                 rch = 1'b0;
	logic                 ceTog = 1'b0;
	logic                 dbl = 1'b0;
	logic                 fault = 1'b0;
	logic                 intDat, stDbl;
	logic                 upDone = 1'b1;
	brw_pkg::brw_status_t stat = '0;
	brw_pkg::brw_flags_t  mask = '0;
	brw_pkg::brw_flags_t  doRead = '0;
	brw_pkg::brw_flags_t  clr;
	brw_pkg::brw_flags_t  flags;
	logic                 busT, intEn, intPin, sysRail, aonRail, hwRst, ship, pause, stRst;
	int                   nFail = 0;
	int                   totalChecks = 0;
	int                   cyc = 0;

	brw_top #(.TICK_CYCLES(TK), .INT_PULSE_CYCLES(PL), .WATCHDOG_TICKS(WD),
		.RAIL_OFF_TICKS(RO)) dut
	(
		.clock(clock), .rstn(rstn), .buttonInputN(btnN), .longPressActionSel(sel),
		.longPressResetMs(pressMs), .resetWarnLeadMs(leadMs),
		.resetNeedsInputPower(needPwr), .inputSupplyValid(supply),
		.softResetRequest(softReq), .adapterWatchdogEnable(wdEn), .busTransaction(busT),
		.startupDone(upDone), .startupFault(fault), .chargerStatus(stat),
		.chargeEnableToggle(ceTog), .rechargeReached(rch), .timerDoubleOption(dbl),
		.flagMask(mask), .flagClear(clr), .flagsOut(flags), .intOut(intDat), .intOutEn(intEn),
		.systemRailEnable(sysRail), .alwaysOnRailEnable(aonRail), .hwResetActive(hwRst),
		.shipModeEntry(ship), .chargePause(pause), .safetyTimerReset(stRst),
		.safetyTimerDouble(stDbl)
	);
	brw_host_model host
	(
		.clock(clock), .intOutEn(intEn), .intOut(intDat), .doBus(doBus), .doRead(doRead),
		.busTransaction(busT), .flagClear(clr), .intPin(intPin)
	);

	// ====================================================================
	// shared tasks
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		totalChecks++;
		if (got !== exp)
		begin
			nFail++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	// length of the next low pulse on the pin, 0 when none starts
	task automatic pulseLen(output int len);
		len = 0;
		repeat (6)
		begin
			@(negedge clock);
			if (intPin === 1'b0)
				break;
		end
		while (intPin === 1'b0 && len < 50)
		begin
			len++;
			@(negedge clock);
		end
	endtask
	task automatic watch(input int lim, output bit r, output bit s, output bit w);
		r = 0;
		s = 0;
		w = 0;
		repeat (lim)
		begin
			@(negedge clock);
			w |= (intEn === 1'b1 && !r);
			r |= (hwRst === 1'b1);
			s |= (ship === 1'b1);
		end
	endtask
	task automatic readAll();
		@(posedge clock) doRead <= 7'h7F;
		@(posedge clock) doRead <= 7'h00;
		tick(3);
	endtask

	// ====================================================================
	// scenarios
	task automatic tIrq();
		int n;
		@(posedge clock) stat.constantVoltage <= 1'b1;
		pulseLen(n);
		chk("cv pulse", 8'(PL), 8'(n));
		chk("cv flag", 1, flags.src.constantVoltage);
		@(posedge clock) stat.constantVoltage <= 1'b0;
		@(posedge clock) stat.constantVoltage <= 1'b1;
		pulseLen(n);
		chk("cv refire", 0, 8'(n));
		readAll();
		@(posedge clock) stat.constantVoltage <= 1'b0;
		@(posedge clock) stat.constantVoltage <= 1'b1;
		pulseLen(n);
		chk("cv after read", 8'(PL), 8'(n));
		@(posedge clock) stat <= '0;
	endtask
	task automatic tMask();
		int n;
		@(posedge clock) mask.src.thermalFoldback <= 1'b1;
		@(posedge clock) stat.thermalFoldback <= 1'b1;
		pulseLen(n);
		chk("masked", 0, 8'(n));
		@(posedge clock) mask.src.thermalFoldback <= 1'b0;
		pulseLen(n);
		chk("unmask held", 0, 8'(n));
		@(posedge clock) stat <= '0;
		dbl <= 1'b1;
		// the four regulation loops sit in the low status bits
		for (int i = 0; i < 4; i++)
		begin
			readAll();
			@(posedge clock) stat <= brw_pkg::brw_status_t'(6'h01 << i);
			pulseLen(n);
			chk("loop pulse", 8'(PL), 8'(n));
			chk("loop flag", 1, flags.src[i]);
			chk("loop double", 1, stDbl);
			@(posedge clock) stat <= '0;
		end
	endtask
	task automatic tDone();
		bit r, s, w;
		@(posedge clock) stat.chargeDone <= 1'b1;
		@(negedge clock);
		chk("pause early", 0, pause);
		repeat (5)
		begin
			@(negedge clock);
			s |= (stRst === 1'b1);
		end
		chk("timer reset", 1, s);
		chk("pause", 1, pause);
		@(posedge clock) rch <= 1'b1;
		@(posedge clock) rch <= 1'b0;
		tick(3);
		@(negedge clock);
		chk("resume", 0, pause);
		@(posedge clock) stat <= '0;
		@(posedge clock) stat.chargeDone <= 1'b1;
		tick(3);
		@(negedge clock);
		chk("pause again", 1, pause);
		@(posedge clock) ceTog <= 1'b1;
		@(posedge clock) ceTog <= 1'b0;
		tick(3);
		@(negedge clock);
		chk("resume toggle", 0, pause);
		@(posedge clock) stat <= '0;
		@(posedge clock) softReq <= 1'b1;
		@(posedge clock) softReq <= 1'b0;
		watch(2, r, s, w);
		chk("soft reset", 1, hwRst);
		chk("system rail", 0, sysRail);
		chk("always-on rail", 1, aonRail);
		tick(RO * TK + 10);
		@(negedge clock);
		chk("reset over", 0, hwRst);
	endtask
	// second reset with a faulty start-up: events still flag but never pulse
	task automatic tFault();
		int n;
		@(posedge clock) rstn <= 1'b0;
		fault <= 1'b1;
		tick(2);
		rstn <= 1'b1;
		tick(4);
		@(posedge clock) stat.constantVoltage <= 1'b1;
		pulseLen(n);
		chk("fault start pulse", 0, 8'(n));
		chk("fault start flag", 1, flags.src.constantVoltage);
		@(posedge clock) stat <= '0;
	endtask
	task automatic tWd(input logic en, input logic bus, input bit expR);
		bit r, s, w;
		@(posedge clock) wdEn <= en;
		supply <= 1'b0;
		tick(2);
		supply <= 1'b1;
		tick(10);
		doBus <= bus;
		tick(1);
		doBus <= 1'b0;
		watch(WD * TK - 30, r, s, w);
		chk("wd early", 0, r);
		watch(40, r, s, w);
		chk("wd reset", expR, r);
		tick(RO * TK + 10);
	endtask
	task automatic tPress(input brw_pkg::brw_action_t a, input brw_pkg::brw_action_t b,
		input logic g, input bit expR, input bit expS);
		bit r, s, w;
		readAll();
		@(posedge clock) sel <= a;
		supply <= ~g;
		needPwr <= g;
		tick(2);
		btnN <= 1'b0;
		tick(4);
		sel <= b;
		watch(40, r, s, w);
		chk("press reset", expR, r);
		chk("press ship", expS, s);
		chk("warning first", 1, w);
		@(posedge clock) btnN <= 1'b1;
		tick(RO * TK + 10);
	endtask

	// ====================================================================
	// run
	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// far above the roughly 1000 cycles the scenarios need
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			nFail++;
			results();
		end
	end
	task automatic results();
		$display("checks %0d mismatches %0d", totalChecks, nFail);
		if (nFail == 0 && totalChecks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		tick(12);
		rstn <= 1'b1;
		tick(4);
		tIrq();
		tMask();
		tDone();
		tWd(1'b0, 1'b0, 0);
		tWd(1'b1, 1'b0, 1);
		tWd(1'b1, 1'b1, 0);
		@(posedge clock) wdEn <= 1'b0;
		tPress(HR, HR, 1'b0, 1, 0);
		tPress(brw_pkg::BRW_LP_SHIP, brw_pkg::BRW_LP_SHIP, 1'b0, 0, 1);
		tPress(brw_pkg::BRW_LP_SHIP_ALT, brw_pkg::BRW_LP_SHIP_ALT, 1'b0, 0, 1);
		tPress(NO, NO, 1'b0, 0, 0);
		tPress(NO, HR, 1'b0, 0, 0);
		tPress(HR, HR, 1'b1, 0, 0);
		tFault();
		results();
	end
endmodule // brw_top_bench
